// ==== core/spc_defines.vh ====
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
`define SPC_OFF_CTRL 2'h0
`define SPC_OFF_FLAGS 2'h1
`define SPC_OFF_FMT 2'h2
`define SPC_CTRL_RST 8'h00
`define SPC_FLAGS_RST 8'h84
`define SPC_FMT_RST 8'h00
`define SPC_B_TIE 7
`define SPC_B_RIE 6
`define SPC_B_TE 5
`define SPC_B_RE 4
`define SPC_B_ADDR_WAIT_IRQ_EN 3
`define SPC_B_TX_DONE_IRQ_EN 2
`define SPC_B_CKHI 1
`define SPC_B_TX_HOLDING_EMPTY 7
`define SPC_B_RX_HOLDING_FULL 6
`define SPC_B_OVERRUN_FLAG 5
`define SPC_B_FER 4
`define SPC_B_PER 3
`define SPC_B_TEND 2
`define SPC_B_MPB 1
`define SPC_B_SYNC 7
`define SPC_B_MP 2
`define SPC_CLR_MASK 8'hF8
`define SPC_RESP_OK 2'h0
`define SPC_RESP_ERR 2'h2
`define SPC_PAD 24'h000000
`endif

// ==== core/spc_serial_port.v ====
// Summary of operation
// - Control register always accessible; zero on reset, standby.
// - Holding-empty request when transfer empties holding.
// - Holding-empty request drops on flag clear, disable.
// - Receive interrupt enable gates full and error requests.
// - Receive requests drop on flag clear, disable.
// - Transmitter off forces holding-empty flag high.
// - Transmit starts once holding written, flag cleared.
// - Receiver disable keeps receive flags unchanged.
// - Reception begins on start bit or clock.
// - Address wait suppresses frames only in asynchronous multiprocessor format; addr_wait_active sets in any format.
// - Address wait suppresses frames with bit zero.
// - Address frame sets bit, ends wait itself.
// - Wait state clears on disable or address frame.
// - Done request when last bit sent, nothing waiting.
// - External async clock runs sixteen times bit rate.
// - Flags clear only after read set; ones ignored.
`include "spc_defines.vh"
module spc_serial_port (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address.
  input wire awvalid,
  output reg awready,
  input wire [3:0] awaddr,
  // AXI4-Lite write data.
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response.
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address.
  input wire arvalid,
  output reg arready,
  input wire [3:0] araddr,
  // AXI4-Lite read data.
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Power state.
  input wire standby,
  // Transmit side events.
  input wire hold_written,
  input wire hold_to_shift,
  input wire shift_idle,
  input wire last_bit_sent,
  // Receive side events.
  input wire start_bit_seen,
  input wire sclk_seen,
  input wire frame_done,
  input wire frame_mpb,
  input wire frame_ferr,
  input wire frame_perr,
  // Controls to the serial engines.
  output reg tx_on,
  output reg rx_on,
  output reg tx_start,
  output reg rx_begin,
  output reg rx_xfer,
  output reg [1:0] clk_src_sel,
  output reg ext_clk_x16,
  output reg addr_wait_active,
  // Interrupt requests.
  output reg tx_empty_irq,
  output reg rx_full_irq,
  output reg rx_error_irq,
  output reg tx_done_irq
);

// ----------------------------------------
// Registers and decode
// ----------------------------------------
reg [7:0] serial_control_reg;
reg [7:0] serial_flags_reg;
reg [7:0] serial_format_reg;
reg [7:0] read_armed;
reg aw_got;
reg w_got;
reg [1:0] aw_idx;
reg aw_ok;
reg [31:0] w_data;
reg w_lane;
wire clr = ~aresetn | standby;
wire aw_hs = awvalid & awready;
wire w_hs = wvalid & wready;
wire ar_hs = arvalid & arready;
wire wr_go = aw_got & w_got & ~bvalid;
wire wr_ctrl = wr_go & aw_ok & w_lane & (aw_idx == `SPC_OFF_CTRL);
wire wr_flags = wr_go & aw_ok & w_lane & (aw_idx == `SPC_OFF_FLAGS);
wire wr_fmt = wr_go & aw_ok & w_lane & (aw_idx == `SPC_OFF_FMT);
wire rd_flags = ar_hs & (araddr[3:2] == `SPC_OFF_FLAGS) & (araddr[1:0] == 2'h0);
wire async_mp = ~serial_format_reg[`SPC_B_SYNC] & serial_format_reg[`SPC_B_MP];
wire [7:0] wr_val = w_data[7:0];
wire [7:0] sw_clear = wr_flags ? (read_armed & ~wr_val & `SPC_CLR_MASK) : 8'h00;

// ----------------------------------------
// Write channel
// ----------------------------------------
always @(posedge aclk) begin
  if (!aresetn) begin
    awready <= 1'b1;
    wready <= 1'b1;
    aw_got <= 1'b0;
    w_got <= 1'b0;
    aw_idx <= 2'h0;
    aw_ok <= 1'b0;
    w_data <= 32'h00000000;
    w_lane <= 1'b0;
    bvalid <= 1'b0;
    bresp <= `SPC_RESP_OK;
  end else begin
    if (aw_hs) begin
      aw_got <= 1'b1;
      awready <= 1'b0;
      aw_idx <= awaddr[3:2];
      aw_ok <= (awaddr[1:0] == 2'h0) & (awaddr[3:2] != 2'h3);
    end
    if (w_hs) begin
      w_got <= 1'b1;
      wready <= 1'b0;
      w_data <= wdata;
      w_lane <= wstrb[0];
    end
    if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= aw_ok ? `SPC_RESP_OK : `SPC_RESP_ERR;
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end
    if (bvalid & bready) begin
      bvalid <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
    end
  end
end

// ----------------------------------------
// Read channel
// ----------------------------------------
always @(posedge aclk) begin
  if (!aresetn) begin
    arready <= 1'b1;
    rvalid <= 1'b0;
    rdata <= 32'h00000000;
    rresp <= `SPC_RESP_OK;
  end else begin
    if (ar_hs) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `SPC_RESP_OK;
      rdata <= 32'h00000000;
      if (araddr[1:0] != 2'h0) begin
        rresp <= `SPC_RESP_ERR;
      end else begin
        case (araddr[3:2])
          `SPC_OFF_CTRL: rdata <= {`SPC_PAD, serial_control_reg};
          `SPC_OFF_FLAGS: rdata <= {`SPC_PAD, serial_flags_reg};
          `SPC_OFF_FMT: rdata <= {`SPC_PAD, serial_format_reg};
          default: rresp <= `SPC_RESP_ERR;
        endcase
      end
    end
    if (rvalid & rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
end

// ----------------------------------------
// Receive frame qualification and transmit end
// ----------------------------------------
wire waiting = serial_control_reg[`SPC_B_ADDR_WAIT_IRQ_EN] & async_mp;
wire addr_frame = frame_done & frame_mpb;
wire take = frame_done & ~(waiting & ~frame_mpb);
wire overrun = take & serial_flags_reg[`SPC_B_RX_HOLDING_FULL];
wire tend_set = last_bit_sent & serial_flags_reg[`SPC_B_TX_HOLDING_EMPTY];

// ----------------------------------------
// Control and format registers
// ----------------------------------------
always @(posedge aclk) begin
  if (clr) begin
    serial_control_reg <= `SPC_CTRL_RST;
    serial_format_reg <= `SPC_FMT_RST;
    addr_wait_active <= 1'b0;
  end else begin
    if (wr_ctrl) begin
      serial_control_reg <= wr_val;
    end
    if (wr_fmt) begin
      serial_format_reg <= wr_val;
    end
    if (addr_frame & waiting) begin
      serial_control_reg[`SPC_B_ADDR_WAIT_IRQ_EN] <= 1'b0;
    end
    if (wr_ctrl & wr_val[`SPC_B_ADDR_WAIT_IRQ_EN]) begin
      addr_wait_active <= 1'b1;
    end
    if ((wr_ctrl & ~wr_val[`SPC_B_ADDR_WAIT_IRQ_EN]) | addr_frame) begin
      addr_wait_active <= 1'b0;
    end
  end
end

// ----------------------------------------
// Status flags
// ----------------------------------------
always @(posedge aclk) begin
  if (clr) begin
    serial_flags_reg <= `SPC_FLAGS_RST;
    read_armed <= 8'h00;
  end else begin
    read_armed <= (read_armed & ~sw_clear) | (rd_flags ? serial_flags_reg : 8'h00);
    serial_flags_reg <= serial_flags_reg & ~sw_clear;
    if (hold_written) begin
      serial_flags_reg[`SPC_B_TX_HOLDING_EMPTY] <= 1'b0;
    end
    if (sw_clear[`SPC_B_TX_HOLDING_EMPTY] | hold_written) begin
      serial_flags_reg[`SPC_B_TEND] <= 1'b0;
    end
    if (tend_set) begin
      serial_flags_reg[`SPC_B_TEND] <= 1'b1;
    end
    if (hold_to_shift | ~serial_control_reg[`SPC_B_TE]) begin
      serial_flags_reg[`SPC_B_TX_HOLDING_EMPTY] <= 1'b1;
    end
    if (frame_done & async_mp) begin
      serial_flags_reg[`SPC_B_MPB] <= frame_mpb;
    end
    if (take) begin
      if (overrun) begin
        serial_flags_reg[`SPC_B_OVERRUN_FLAG] <= 1'b1;
      end else begin
        serial_flags_reg[`SPC_B_RX_HOLDING_FULL] <= 1'b1;
      end
      if (frame_ferr) begin
        serial_flags_reg[`SPC_B_FER] <= 1'b1;
      end
      if (frame_perr & ~async_mp) begin
        serial_flags_reg[`SPC_B_PER] <= 1'b1;
      end
    end
  end
end

// ----------------------------------------
// Engine controls
// ----------------------------------------
always @(posedge aclk) begin
  if (clr) begin
    tx_on <= 1'b0;
    rx_on <= 1'b0;
    tx_start <= 1'b0;
    rx_begin <= 1'b0;
    rx_xfer <= 1'b0;
    clk_src_sel <= 2'h0;
    ext_clk_x16 <= 1'b0;
  end else begin
    tx_on <= serial_control_reg[`SPC_B_TE];
    rx_on <= serial_control_reg[`SPC_B_RE];
    clk_src_sel <= serial_control_reg[`SPC_B_CKHI:0];
    ext_clk_x16 <= serial_control_reg[`SPC_B_CKHI] & ~serial_format_reg[`SPC_B_SYNC];
    tx_start <= serial_control_reg[`SPC_B_TE] & ~serial_flags_reg[`SPC_B_TX_HOLDING_EMPTY]
      & shift_idle & ~tx_start & ~hold_to_shift;
    rx_begin <= serial_control_reg[`SPC_B_RE] & (serial_format_reg[`SPC_B_SYNC]
      ? sclk_seen : start_bit_seen);
    rx_xfer <= take & ~overrun & serial_control_reg[`SPC_B_RE];
  end
end

// ----------------------------------------
// Interrupt requests
// ----------------------------------------
always @(posedge aclk) begin
  if (clr) begin
    tx_empty_irq <= 1'b0;
    rx_full_irq <= 1'b0;
    rx_error_irq <= 1'b0;
    tx_done_irq <= 1'b0;
  end else begin
    tx_empty_irq <= serial_control_reg[`SPC_B_TIE] & serial_flags_reg[`SPC_B_TX_HOLDING_EMPTY];
    rx_full_irq <= serial_control_reg[`SPC_B_RIE] & serial_flags_reg[`SPC_B_RX_HOLDING_FULL];
    rx_error_irq <= serial_control_reg[`SPC_B_RIE] & (serial_flags_reg[`SPC_B_OVERRUN_FLAG]
      | serial_flags_reg[`SPC_B_FER] | serial_flags_reg[`SPC_B_PER]);
    tx_done_irq <= serial_control_reg[`SPC_B_TX_DONE_IRQ_EN] & serial_flags_reg[`SPC_B_TEND];
  end
end

endmodule // spc_serial_port

// ==== test/spc_chk.sv ====
module spc_chk (
  // Watched ports.
  input logic aclk,
  input logic aresetn,
  input logic awready,
  input logic wready,
  input logic bvalid,
  input logic rvalid,
  input logic rready,
  input logic standby,
  input logic shift_idle,
  input logic start_bit_seen,
  input logic sclk_seen,
  input logic frame_done,
  input logic frame_mpb,
  input logic tx_on,
  input logic rx_on,
  input logic tx_start,
  input logic rx_begin,
  input logic rx_xfer,
  input logic [1:0] clk_src_sel,
  input logic ext_clk_x16,
  input logic addr_wait_active,
  input logic tx_empty_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_standby_clear: assert property (standby |=> !tx_on && !rx_on && !tx_empty_irq)
    else $error("Outputs kept through standby.");
  chk_tx_start_cause: assert property (tx_start |-> $past(shift_idle) && !$past(tx_start))
    else $error("Transmit start without cause.");
  chk_rx_begin_cause: assert property (rx_begin |-> $past(start_bit_seen || sclk_seen))
    else $error("Receive begin without cause.");
  chk_rx_xfer_cause: assert property (rx_xfer |-> $past(frame_done))
    else $error("Receive transfer without frame.");
  chk_wait_ends: assert property (addr_wait_active && frame_done && frame_mpb |=> !addr_wait_active)
    else $error("Address wait kept after address frame.");
  chk_x16_source: assert property (ext_clk_x16 |-> clk_src_sel[1])
    else $error("Sixteen times clock without external source.");
  chk_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("Write accepted while response pending.");
  chk_read_once: assert property (rvalid && rready |=> !rvalid)
    else $error("Read data repeated.");
endmodule // spc_chk

bind spc_serial_port spc_chk i_spc_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .awready(awready),
  .wready(wready),
  .bvalid(bvalid),
  .rvalid(rvalid),
  .rready(rready),
  .standby(standby),
  .shift_idle(shift_idle),
  .start_bit_seen(start_bit_seen),
  .sclk_seen(sclk_seen),
  .frame_done(frame_done),
  .frame_mpb(frame_mpb),
  .tx_on(tx_on),
  .rx_on(rx_on),
  .tx_start(tx_start),
  .rx_begin(rx_begin),
  .rx_xfer(rx_xfer),
  .clk_src_sel(clk_src_sel),
  .ext_clk_x16(ext_clk_x16),
  .addr_wait_active(addr_wait_active),
  .tx_empty_irq(tx_empty_irq)
);

// ==== test/spc_far.sv ====
module spc_far (
  // Clock.
  input logic aclk,
  // Transmit engine events.
  output logic shift_idle,
  output logic hold_written,
  output logic hold_to_shift,
  output logic last_bit_sent,
  // Receive engine events.
  output logic start_bit_seen,
  output logic sclk_seen,
  output logic frame_done,
  output logic frame_mpb,
  output logic frame_ferr,
  output logic frame_perr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {shift_idle, hold_written, hold_to_shift, last_bit_sent, start_bit_seen} = 5'h00;
    {sclk_seen, frame_done, frame_mpb, frame_ferr, frame_perr} = 5'h00;
  end
  // Idle level and one-cycle transmit pulses.
  task tx(input logic [3:0] v);
    @(posedge aclk);
    {shift_idle, hold_written, hold_to_shift, last_bit_sent} <= v;
    @(posedge aclk);
    {hold_written, hold_to_shift, last_bit_sent} <= 3'h0;
  endtask
  // A received frame; qualifiers are inverted after the valid cycle.
  task frame(input logic m, input logic f, input logic p);
    @(posedge aclk);
    start_bit_seen <= 1'b1;
    @(posedge aclk);
    start_bit_seen <= 1'b0;
    repeat (2) @(posedge aclk);
    {frame_done, frame_mpb, frame_ferr, frame_perr} <= {1'b1, m, f, p};
    @(posedge aclk);
    {frame_done, frame_mpb, frame_ferr, frame_perr} <= {1'b0, ~m, ~f, ~p};
  endtask
endmodule // spc_far

// ==== test/spc_serial_port_bench.sv ====
module spc_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, standby;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, clk_src_sel, r, b;
  logic awready, wready, bvalid, arready, rvalid, tx_on, rx_on, tx_start, rx_begin, rx_xfer;
  logic ext_clk_x16, addr_wait_active, tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
  logic hold_written, hold_to_shift, shift_idle, last_bit_sent, start_bit_seen, sclk_seen;
  logic frame_done, frame_mpb, frame_ferr, frame_perr;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  int xfers = 0;
  int begins = 0;
  spc_serial_port i_spc_serial_port (.*);
  spc_far i_spc_far (.*);
  always @(posedge aclk) begin
    if (rx_xfer === 1'b1) xfers++;
    if (rx_begin === 1'b1) begins++;
  end
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------
  // Tasks.
  // ----------
  task cmpw(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task cmpb(input string s, input logic e, input logic g);
    cmpw(s, {31'h0, e}, {31'h0, g});
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      b = bresp;
    end while (!bvalid);
  endtask
  task rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
    end while (!rvalid);
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    cmpw("register", e, d);
  endtask
  task complete_run;
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    complete_run;
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, standby} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    {wstrb, bready, rready} = 6'h3F;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(4'h0, 32'h00);
    rc(4'h4, 32'h84);
    rd(4'hC);
    cmpw("rresp", 32'h2, {30'h0, r});
    cmpw("rdata", 32'h0, d);
    wr(4'hC, 32'hFF);
    cmpw("bresp", 32'h2, {30'h0, b});
    wr(4'h8, 32'h00);
    cmpw("bresp", 32'h0, {30'h0, b});
    wr(4'h0, 32'hA0);
    repeat (3) @(posedge aclk);
    cmpb("tx_empty_irq", 1'b1, tx_empty_irq);
    rc(4'h4, 32'h84);
    wr(4'h4, 32'h7C);
    repeat (3) @(posedge aclk);
    cmpb("tx_empty_irq", 1'b0, tx_empty_irq);
    i_spc_far.tx(4'h4);
    i_spc_far.tx(4'h8);
    n = 0;
    while (tx_start !== 1'b1 && n < 9) begin
      @(posedge aclk);
      n++;
    end
    cmpb("tx_start", 1'b1, tx_start);
    i_spc_far.tx(4'h2);
    repeat (3) @(posedge aclk);
    cmpb("tx_empty_irq", 1'b1, tx_empty_irq);
    wr(4'h0, 32'h20);
    repeat (3) @(posedge aclk);
    cmpb("tx_empty_irq", 1'b0, tx_empty_irq);
    i_spc_far.tx(4'h4);
    wr(4'h0, 32'h50);
    rc(4'h4, 32'h80);
    i_spc_far.frame(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge aclk);
    cmpb("rx_full_irq", 1'b1, rx_full_irq);
    wr(4'h0, 32'h10);
    repeat (3) @(posedge aclk);
    cmpb("rx_full_irq", 1'b0, rx_full_irq);
    wr(4'h0, 32'h00);
    rc(4'h4, 32'hC0);
    cmpb("rx_on", 1'b0, rx_on);
    wr(4'h4, 32'h00);
    wr(4'h8, 32'h04);
    wr(4'h0, 32'h58);
    repeat (2) @(posedge aclk);
    cmpb("addr_wait_active", 1'b1, addr_wait_active);
    i_spc_far.frame(1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge aclk);
    cmpb("rx_full_irq", 1'b0, rx_full_irq);
    cmpb("rx_error_irq", 1'b0, rx_error_irq);
    rc(4'h4, 32'h80);
    i_spc_far.frame(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge aclk);
    cmpb("addr_wait_active", 1'b0, addr_wait_active);
    cmpb("rx_full_irq", 1'b1, rx_full_irq);
    rc(4'h0, 32'h50);
    rc(4'h4, 32'hC2);
    i_spc_far.frame(1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge aclk);
    cmpb("rx_error_irq", 1'b1, rx_error_irq);
    rc(4'h4, 32'hF2);
    cmpw("rx_xfer count", 32'h2, xfers);
    cmpw("rx_begin count", 32'h4, begins);
    @(posedge aclk) standby <= 1'b1;
    @(posedge aclk) standby <= 1'b0;
    rc(4'h0, 32'h00);
    rc(4'h4, 32'h84);
    cmpb("rx_error_irq", 1'b0, rx_error_irq);
    wr(4'h0, 32'h26);
    repeat (2) @(posedge aclk);
    cmpw("clk_src_sel", 32'h2, {30'h0, clk_src_sel});
    cmpb("ext_clk_x16", 1'b1, ext_clk_x16);
    cmpb("tx_on", 1'b1, tx_on);
    i_spc_far.tx(4'h4);
    repeat (3) @(posedge aclk);
    cmpb("tx_done_irq", 1'b0, tx_done_irq);
    i_spc_far.tx(4'h2);
    i_spc_far.tx(4'h1);
    repeat (3) @(posedge aclk);
    cmpb("tx_done_irq", 1'b1, tx_done_irq);
    complete_run;
  end
endmodule // spc_serial_port_bench
